//--- cmp_cfg.svh
// Constants for the configuration mode port: mode codes, pin bit positions and counts.
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH
`define CMP_MODE_MSER 3'h0
`define CMP_MODE_SSER 3'h7
`define CMP_MODE_MBYTE 3'h3
`define CMP_MODE_SBYTE 3'h6
`define CMP_MODE_JTAG 3'h5
`define CMP_SYNC_W 17
`define CMP_SYNC_RST 17'h1ffff
`define CMP_PIN_RESTART 16
`define CMP_PIN_PULLDIS 15
`define CMP_PIN_MODE_HI 14
`define CMP_PIN_MODE_LO 12
`define CMP_PIN_CFG_CLK 11
`define CMP_PIN_DIN 10
`define CMP_PIN_CS 9
`define CMP_PIN_DIR 8
`define CMP_PIN_DATA_HI 7
`define CMP_CLEAR_NS 80
`define CMP_CLK_NS 5
`define CMP_CLEAR_CYCLES 8'(`CMP_CLEAR_NS / `CMP_CLK_NS)
`define CMP_SLOW_HALF 8'h20
`define CMP_BITS_W 25
`define CMP_RATE_W 4
`endif

//--- cmp_config_port.sv
// Configuration load front end: mode decode, serial and byte loading, forwarding and start-up.
// Summary of operation
// (R1) Decode five modes; serial 1, byte 8 bits.
// (R2) Floating mode pins select slave serial loading.
// (R3) Pull-up control high disables user pull-ups.
// (R4) Masters drive config clock; slaves receive it.
// (R5) Source sets serial bit before rising edge.
// (R6) After load, forward data on rising edge.
// (R7) Forwarding only in the two serial modes.
// (R8) Master serial clock starts slow, then speeds.
// (R9) Slave byte source supplies data, clock, selects.
// (R10) Busy high holds the current byte.
// (R11) Direction asserted reads configuration data back.
// (R12) Controller selects one device at a time.
// (R13) Master byte mode drives its own clock.
// (R14) Test-port loading works in every mode.
// (R15) Test-port loading through standard access port.
// (R16) Persist keeps pins; otherwise they become user.
// (R17) Restart reloads; init marks clear, done completion.
// (R18) Tristate released one edge after done, write next.
// (R19) Undefined mode codes leave only test-port loading.
`timescale 1ns/10ps
`include "cmp_cfg.svh"
module cmp_config_port import cmp_pkg::*; (
    // Clocking
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Mode and option pins
    input wire logic mode_sel_2,
    input wire logic mode_sel_1,
    input wire logic mode_sel_0,
    input wire logic io_pullup_disable,
    input wire logic cfg_restart_n,
    input wire logic persist_opt,
    // Configuration clock pin
    input wire logic cfg_clk_i,
    output logic cfg_clk_o,
    output logic cfg_clk_oe,
    // Serial pins
    input wire logic din,
    output logic dout,
    // Byte port pins
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe,
    input wire logic cs_n,
    input wire logic port_dir_n,
    output logic busy,
    // Test access port load stream
    input wire logic tap_bit_valid,
    input wire logic tap_bit,
    // Frame writer side
    input wire logic [`CMP_BITS_W-1:0] load_len_bits,
    output logic [7:0] cfg_word,
    output logic cfg_word_valid,
    input wire logic cfg_word_ready,
    input wire logic [7:0] rb_data,
    output logic rb_req,
    // Status
    output logic init_done,
    output logic done,
    output logic global_out_tristate,
    output logic global_write_en,
    output logic io_pullup_en,
    output logic pins_user_io
);
    logic [`CMP_SYNC_W-1:0] pin_q;
    cmp_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin_async({cfg_restart_n, io_pullup_disable, mode_sel_2, mode_sel_1, mode_sel_0,
                    cfg_clk_i, din, cs_n, port_dir_n, data_i}),
        .pin_q(pin_q)
    );
    logic restart_s, pulldis_s, cfg_clk_s, din_s, cs_n_s, dir_n_s;
    logic [2:0] mode_s;
    logic [7:0] data_s;
    assign restart_s = pin_q[`CMP_PIN_RESTART];
    assign pulldis_s = pin_q[`CMP_PIN_PULLDIS];
    assign mode_s = pin_q[`CMP_PIN_MODE_HI:`CMP_PIN_MODE_LO];
    assign cfg_clk_s = pin_q[`CMP_PIN_CFG_CLK];
    assign din_s = pin_q[`CMP_PIN_DIN];
    assign cs_n_s = pin_q[`CMP_PIN_CS];
    assign dir_n_s = pin_q[`CMP_PIN_DIR];
    assign data_s = pin_q[`CMP_PIN_DATA_HI:0];
    cmp_state_e state_reg, state_next;
    cmp_mode_e mode_reg, mode_next;
    logic [7:0] clr_cnt_reg, clr_cnt_next, div_cnt_reg, div_cnt_next, half_reg, half_next;
    logic [7:0] shift_reg, shift_next, word_reg, word_next, data_o_reg, data_o_next;
    logic [2:0] nbit_reg, nbit_next;
    logic [`CMP_BITS_W-1:0] bits_reg, bits_next;
    logic cfg_clk_prev_reg, cfg_clk_prev_next, cfg_clk_o_reg, cfg_clk_o_next, cfg_clk_oe_reg, cfg_clk_oe_next;
    logic first_reg, first_next, valid_reg, valid_next, busy_reg, busy_next;
    logic dout_reg, dout_next, data_oe_reg, data_oe_next, rb_reg, rb_next;
    logic init_reg, init_next, done_reg, done_next, gts_reg, gts_next, gwe_reg, gwe_next;
    logic pull_reg, pull_next, user_reg, user_next;
    logic is_master, is_serial, is_byte, ext_rise, int_rise, rise, emit;
    logic [7:0] emit_word;
    logic [`CMP_BITS_W-1:0] add_bits;
    // Mode decode from the synchronised mode pins; only used when the clear phase ends.
    function automatic cmp_mode_e decode_mode(input logic [2:0] m);
        case (m) // R1
            `CMP_MODE_MSER: decode_mode = MODE_MSER;
            `CMP_MODE_SSER: decode_mode = MODE_SSER;
            `CMP_MODE_MBYTE: decode_mode = MODE_MBYTE;
            `CMP_MODE_SBYTE: decode_mode = MODE_SBYTE;
            `CMP_MODE_JTAG: decode_mode = MODE_JTAG;
            default: decode_mode = MODE_NONE; // R19
        endcase
    endfunction
    always_comb begin
        is_master = (mode_reg == MODE_MSER) || (mode_reg == MODE_MBYTE);
        is_serial = (mode_reg == MODE_MSER) || (mode_reg == MODE_SSER);
        is_byte = (mode_reg == MODE_MBYTE) || (mode_reg == MODE_SBYTE);
        ext_rise = cfg_clk_s && !cfg_clk_prev_reg;
        int_rise = (div_cnt_reg == 8'h00) && !cfg_clk_o_reg;
        // Slaves time everything from the pin; the others from the internal divider.
        rise = ((mode_reg == MODE_SSER) || (mode_reg == MODE_SBYTE)) ? ext_rise : int_rise; // R4
    end
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        clr_cnt_next = clr_cnt_reg;
        half_next = half_reg;
        shift_next = shift_reg;
        word_next = word_reg;
        data_o_next = data_o_reg;
        nbit_next = nbit_reg;
        bits_next = bits_reg;
        cfg_clk_prev_next = cfg_clk_s;
        first_next = first_reg;
        dout_next = dout_reg;
        data_oe_next = 1'b0;
        rb_next = 1'b0;
        init_next = init_reg;
        done_next = done_reg;
        gts_next = gts_reg;
        gwe_next = gwe_reg;
        emit = 1'b0;
        emit_word = shift_reg;
        add_bits = '0;
        div_cnt_next = div_cnt_reg - 8'h01;
        cfg_clk_o_next = cfg_clk_o_reg;
        if (div_cnt_reg == 8'h00) begin
            div_cnt_next = half_reg;
            cfg_clk_o_next = !cfg_clk_o_reg;
        end
        case (state_reg)
            ST_CLEAR: begin
                init_next = 1'b0;
                clr_cnt_next = clr_cnt_reg + 8'h01;
                if (clr_cnt_reg == `CMP_CLEAR_CYCLES) begin
                    mode_next = decode_mode(mode_s); // R1 R2 R19
                    init_next = 1'b1; // R17
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (tap_bit_valid) begin
                    // The test port is always open and wins a clash with a pin edge.
                    shift_next = {shift_reg[6:0], tap_bit}; // R14 R15
                    nbit_next = nbit_reg + 3'h1;
                    add_bits = `CMP_BITS_W'(1);
                    emit = (nbit_reg == 3'h7);
                    emit_word = shift_next;
                end else if (rise && is_serial) begin
                    shift_next = {shift_reg[6:0], din_s}; // R1 R5
                    nbit_next = nbit_reg + 3'h1;
                    add_bits = `CMP_BITS_W'(1);
                    emit = (nbit_reg == 3'h7);
                    emit_word = shift_next;
                end else if (is_byte && !cs_n_s) begin // R9 R12 R13
                    if (dir_n_s) begin
                        data_oe_next = 1'b1; // R11
                        rb_next = rise;
                        data_o_next = rb_data;
                    end else if (rise && !busy_reg) begin // R10
                        emit = 1'b1;
                        emit_word = data_s;
                        add_bits = `CMP_BITS_W'(8); // R1
                    end
                end
                bits_next = bits_reg + add_bits;
                if (emit) begin
                    word_next = emit_word;
                    first_next = 1'b0;
                    // The first word carries the rate code for the master serial clock.
                    if (first_reg && mode_reg == MODE_MSER && emit_word[`CMP_RATE_W-1:0] != '0) begin
                        half_next = {4'h0, emit_word[`CMP_RATE_W-1:0]}; // R8
                    end
                end
                if (bits_next >= load_len_bits) begin
                    done_next = 1'b1; // R17
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (rise) begin
                    gts_next = 1'b0; // R18
                    state_next = ST_GTS;
                end
            end
            ST_GTS: begin
                if (rise) begin
                    gwe_next = 1'b1; // R18
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // The port stays for readback only with the persist option.
                if (persist_opt && is_byte && !cs_n_s && dir_n_s) begin // R16
                    data_oe_next = 1'b1;
                    rb_next = rise;
                    data_o_next = rb_data;
                end
            end
            default: state_next = ST_CLEAR;
        endcase
        // Once own load is complete, serial modes pass later data downstream.
        if (state_reg != ST_CLEAR && state_reg != ST_LOAD && is_serial && rise) begin
            dout_next = din_s; // R6 R7
        end
        valid_next = emit || (valid_reg && !cfg_word_ready);
        busy_next = is_byte && valid_next; // R10
        cfg_clk_oe_next = is_master && state_reg != ST_CLEAR && !(state_reg == ST_RUN && !persist_opt); // R4 R13
        pull_next = !pulldis_s && (state_reg == ST_CLEAR || state_reg == ST_LOAD); // R3
        user_next = (state_reg == ST_RUN) && !persist_opt; // R16
        if (!restart_s) begin
            state_next = ST_CLEAR; // R17
            clr_cnt_next = 8'h00;
            bits_next = '0;
            nbit_next = 3'h0;
            first_next = 1'b1;
            half_next = `CMP_SLOW_HALF; // R8
            done_next = 1'b0;
            gts_next = 1'b1;
            gwe_next = 1'b0;
            valid_next = 1'b0;
            busy_next = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_CLEAR;
            mode_reg <= MODE_SSER; // R2
            clr_cnt_reg <= 8'h00;
            div_cnt_reg <= 8'h00;
            half_reg <= `CMP_SLOW_HALF;
            shift_reg <= 8'h00;
            word_reg <= 8'h00;
            data_o_reg <= 8'h00;
            nbit_reg <= 3'h0;
            bits_reg <= '0;
            cfg_clk_prev_reg <= 1'b1;
            cfg_clk_o_reg <= 1'b0;
            cfg_clk_oe_reg <= 1'b0;
            first_reg <= 1'b1;
            valid_reg <= 1'b0;
            busy_reg <= 1'b0;
            dout_reg <= 1'b0;
            data_oe_reg <= 1'b0;
            rb_reg <= 1'b0;
            init_reg <= 1'b0;
            done_reg <= 1'b0;
            gts_reg <= 1'b1;
            gwe_reg <= 1'b0;
            pull_reg <= 1'b0;
            user_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            clr_cnt_reg <= clr_cnt_next;
            div_cnt_reg <= div_cnt_next;
            half_reg <= half_next;
            shift_reg <= shift_next;
            word_reg <= word_next;
            data_o_reg <= data_o_next;
            nbit_reg <= nbit_next;
            bits_reg <= bits_next;
            cfg_clk_prev_reg <= cfg_clk_prev_next;
            cfg_clk_o_reg <= cfg_clk_o_next;
            cfg_clk_oe_reg <= cfg_clk_oe_next;
            first_reg <= first_next;
            valid_reg <= valid_next;
            busy_reg <= busy_next;
            dout_reg <= dout_next;
            data_oe_reg <= data_oe_next;
            rb_reg <= rb_next;
            init_reg <= init_next;
            done_reg <= done_next;
            gts_reg <= gts_next;
            gwe_reg <= gwe_next;
            pull_reg <= pull_next;
            user_reg <= user_next;
        end
    end
    assign cfg_clk_o = cfg_clk_o_reg;
    assign cfg_clk_oe = cfg_clk_oe_reg;
    assign dout = dout_reg;
    assign data_o = data_o_reg;
    assign data_oe = data_oe_reg;
    assign busy = busy_reg;
    assign cfg_word = word_reg;
    assign cfg_word_valid = valid_reg;
    assign rb_req = rb_reg;
    assign init_done = init_reg;
    assign done = done_reg;
    assign global_out_tristate = gts_reg;
    assign global_write_en = gwe_reg;
    assign io_pullup_en = pull_reg;
    assign pins_user_io = user_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_clock_dir_slave: assert property (clk_en && (mode_reg == MODE_SSER || mode_reg == MODE_SBYTE) |=> !cfg_clk_oe) // R4
        else $error("config clock driven in slave mode");
    a_fwd_only_serial: assert property (clk_en && !is_serial && $stable(mode_reg) |=> $stable(dout)) // R7
        else $error("forwarding outside serial mode");
    a_busy_holds_word: assert property (busy && clk_en && restart_s && !cfg_word_ready |=> cfg_word_valid) // R10
        else $error("held word lost while busy");
    a_readback_drive: assert property (data_oe |-> is_byte && $past(dir_n_s) && !$past(cs_n_s)) // R11
        else $error("byte port driven without readback");
    a_pullup_ctrl: assert property (clk_en && pulldis_s |=> !io_pullup_en) // R3
        else $error("user pull-ups on while disabled");
    a_gts_after_done: assert property ($fell(global_out_tristate) |-> done && $past(state_reg) == ST_DONE) // R18
        else $error("tristate released out of order");
    a_gwe_after_gts: assert property ($rose(global_write_en) |-> !global_out_tristate && !$past(global_out_tristate)) // R18
        else $error("write enable before tristate release");
    a_restart_clears: assert property (clk_en && !restart_s |=> !done && state_reg == ST_CLEAR) // R17
        else $error("restart did not start a new load");
    a_undefined_mode: assert property (mode_reg == MODE_NONE |-> !cfg_clk_oe && !data_oe) // R19
        else $error("undefined mode drives port");
    a_serial_word: assert property (is_serial && !tap_bit_valid && nbit_reg != 3'h7 |=> $stable(cfg_word)) // R1
        else $error("serial word not eight bits");
    c_serial_done: cover property (is_serial && $rose(done));
    c_byte_busy: cover property (is_byte && busy ##1 !busy);
    c_readback: cover property (rb_req);
    c_startup: cover property ($rose(global_write_en));
endmodule // cmp_config_port

//--- cmp_pkg.sv
// Types for the configuration mode port.
package cmp_pkg;
    typedef enum logic [2:0] {MODE_MSER, MODE_SSER, MODE_MBYTE, MODE_SBYTE, MODE_JTAG, MODE_NONE} cmp_mode_e;
    typedef enum logic [2:0] {ST_CLEAR, ST_LOAD, ST_DONE, ST_GTS, ST_RUN} cmp_state_e;
endpackage

//--- cmp_src_model.sv
// Behavioural configuration source: serial bit stream and byte port with busy flow control.
`timescale 1ns/10ps
module cmp_src_model (
    // Clocking
    input wire logic clk,
    // Lines towards the port
    output logic cfg_clk_i,
    output logic din,
    output logic [7:0] data_i,
    output logic cs_n,
    output logic port_dir_n,
    // Answers from the port
    input wire logic busy,
    input wire logic [7:0] data_o,
    input wire logic data_oe
);
    initial begin
        cfg_clk_i = 1'b0;
        din = 1'b0;
        data_i = 8'h00;
        cs_n = 1'b1;
        port_dir_n = 1'b0;
    end
    // One link clock period of 32 cycles; the clock stands still between frames.
    task automatic pulse(input int lead);
        repeat (lead) @(posedge clk);
        cfg_clk_i <= 1'b1;
        repeat (16) @(posedge clk);
        cfg_clk_i <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // Released data lines show the inverse so a stale value can never pass as fresh.
    task automatic send_bits(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            din <= v[i];
            pulse(7);
        end
        din <= ~v[0];
    endtask
    task automatic write_byte(input logic [7:0] b);
        logic hit;
        hit = 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        port_dir_n <= 1'b0;
        data_i <= b;
        for (int i = 0; i < 60 && !hit; i++) begin
            repeat (8) @(posedge clk);
            hit = (busy === 1'b0);
            pulse(0);
        end
        cs_n <= 1'b1;
        data_i <= ~b;
    endtask
    task automatic read_byte(output logic [7:0] v, output logic oe);
        @(posedge clk);
        cs_n <= 1'b0;
        port_dir_n <= 1'b1;
        data_i <= ~data_i;
        repeat (8) @(posedge clk);
        cfg_clk_i <= 1'b1;
        repeat (16) @(posedge clk);
        v = data_o;
        oe = data_oe;
        cfg_clk_i <= 1'b0;
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        port_dir_n <= 1'b0;
    endtask
endmodule // cmp_src_model

//--- cmp_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/10ps
`include "cmp_cfg.svh"
module cmp_sync (
    // Clocking
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Pins and filtered result
    input wire logic [`CMP_SYNC_W-1:0] pin_async,
    output logic [`CMP_SYNC_W-1:0] pin_q
);
    logic [`CMP_SYNC_W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [`CMP_SYNC_W-1:0] s1_next, s2_next, s3_next, q_next;
    genvar i;
    generate
        for (i = 0; i < `CMP_SYNC_W; i++) begin : g_bit
            // A change is accepted only once the second and third stages agree.
            always_comb begin
                s1_next[i] = pin_async[i];
                s2_next[i] = s1_reg[i];
                s3_next[i] = s2_reg[i];
                q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_reg <= `CMP_SYNC_RST;
            s2_reg <= `CMP_SYNC_RST;
            s3_reg <= `CMP_SYNC_RST;
            q_reg <= `CMP_SYNC_RST;
        end else if (clk_en) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            q_reg <= q_next;
        end
    end
    assign pin_q = q_reg;
endmodule // cmp_sync

//--- config_mode_port_test.sv
// Self-checking bench for the configuration mode port.
`timescale 1ns/10ps
`include "cmp_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module config_mode_port_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic mode_sel_2 = 1'b1, mode_sel_1 = 1'b1, mode_sel_0 = 1'b1;
    logic io_pullup_disable = 1'b0, cfg_restart_n = 1'b1, persist_opt = 1'b0;
    logic cfg_clk_i, cfg_clk_o, cfg_clk_oe, din, dout, cs_n, port_dir_n, busy, data_oe;
    logic [7:0] data_i, data_o, cfg_word, rb_data = 8'h00;
    logic tap_bit_valid = 1'b0, tap_bit = 1'b0, cfg_word_valid, cfg_word_ready = 1'b1, rb_req;
    logic [`CMP_BITS_W-1:0] load_len_bits = `CMP_BITS_W'(16);
    logic init_done, done, global_out_tristate, global_write_en, io_pullup_en, pins_user_io;
    int errors = 0;
    int n_tests = 0;
    int seed = 84155;
    int n_rb = 0;
    int n;
    logic [7:0] got[$];
    logic [7:0] b[3];
    logic [7:0] v;
    logic oe;
    logic [2:0] modes[4] = '{3'h1, 3'h2, 3'h4, `CMP_MODE_JTAG};

    always #2.5 clk = ~clk;

    cmp_config_port dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .mode_sel_2(mode_sel_2),
        .mode_sel_1(mode_sel_1), .mode_sel_0(mode_sel_0), .io_pullup_disable(io_pullup_disable),
        .cfg_restart_n(cfg_restart_n), .persist_opt(persist_opt), .cfg_clk_i(cfg_clk_i),
        .cfg_clk_o(cfg_clk_o), .cfg_clk_oe(cfg_clk_oe), .din(din), .dout(dout), .data_i(data_i),
        .data_o(data_o), .data_oe(data_oe), .cs_n(cs_n), .port_dir_n(port_dir_n), .busy(busy),
        .tap_bit_valid(tap_bit_valid), .tap_bit(tap_bit), .load_len_bits(load_len_bits),
        .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid), .cfg_word_ready(cfg_word_ready),
        .rb_data(rb_data), .rb_req(rb_req), .init_done(init_done), .done(done),
        .global_out_tristate(global_out_tristate), .global_write_en(global_write_en),
        .io_pullup_en(io_pullup_en), .pins_user_io(pins_user_io));

    cmp_src_model src (.clk(clk), .cfg_clk_i(cfg_clk_i), .din(din), .data_i(data_i), .cs_n(cs_n),
        .port_dir_n(port_dir_n), .busy(busy), .data_o(data_o), .data_oe(data_oe));

    always @(posedge clk) begin
        if (cfg_word_valid === 1'b1 && cfg_word_ready === 1'b1) got.push_back(cfg_word);
        if (rb_req === 1'b1) n_rb++;
    end

    function automatic logic exp_pullup(input logic dis, input logic loading);
        return loading & ~dis;
    endfunction

    task automatic wait_flag(input bit on_done, input int n);
        for (int i = 0; i < n && (on_done ? done : init_done) !== 1'b1; i++) @(posedge clk);
    endtask

    // Counts the cycles of one fresh high phase of the driven config clock.
    task automatic cfg_clk_high(output int n);
        for (int i = 0; i < 300 && cfg_clk_o !== 1'b0; i++) @(posedge clk);
        for (int i = 0; i < 300 && cfg_clk_o !== 1'b1; i++) @(posedge clk);
        for (n = 0; n < 300 && cfg_clk_o === 1'b1; n++) @(posedge clk);
    endtask

    task automatic restart(input logic [2:0] m, input int len, input logic pd);
        @(posedge clk);
        {mode_sel_2, mode_sel_1, mode_sel_0} <= m;
        load_len_bits <= `CMP_BITS_W'(len);
        io_pullup_disable <= pd;
        cfg_restart_n <= 1'b0;
        repeat (12) @(posedge clk);
        cfg_restart_n <= 1'b1;
        got.delete();
        wait_flag(0, 200);
        `CHK(init_done, 1'b1)
    endtask

    task final_report;
        $display("Counts: %0d compares, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Mode pins left high stand for floating pins held by their pull-ups.
        wait_flag(0, 200);
        `CHK(dut.mode_reg, cmp_pkg::MODE_SSER)
        `CHK(io_pullup_en, exp_pullup(io_pullup_disable, 1'b1))
        `CHK(cfg_clk_oe, 1'b0)
        b[0] = 8'($random(seed));
        b[1] = 8'($random(seed));
        src.send_bits(b[0], 8);
        src.send_bits(b[1], 8);
        repeat (4) @(posedge clk);
        `CHK(got[0], b[0])
        `CHK(got[1], b[1])
        `CHK(done, 1'b1)
        `CHK(global_out_tristate, 1'b1)
        v = 8'($random(seed));
        src.send_bits(v, 1);
        `CHK(global_out_tristate, 1'b0)
        `CHK(global_write_en, 1'b0)
        `CHK(dout, v[0])
        v = ~v;
        src.send_bits(v, 1);
        `CHK(global_write_en, 1'b1)
        `CHK(dout, v[0])
        `CHK(pins_user_io, 1'b1)
        `CHK(io_pullup_en, exp_pullup(io_pullup_disable, 1'b0))
        $display("test slave serial done");

        restart(`CMP_MODE_SBYTE, 24, 1'b1);
        `CHK(io_pullup_en, exp_pullup(1'b1, 1'b1))
        `CHK(cfg_clk_oe, 1'b0)
        @(posedge clk);
        rb_data <= 8'($random(seed));
        src.read_byte(v, oe);
        `CHK(oe, 1'b1)
        `CHK(v, rb_data)
        `CHK(n_rb, 1)
        foreach (b[i]) b[i] = 8'($random(seed));
        @(posedge clk);
        cfg_word_ready <= 1'b0;
        src.write_byte(b[0]);
        fork
            src.write_byte(b[1]);
            begin
                repeat (80) @(posedge clk);
                `CHK(busy, 1'b1)
                cfg_word_ready <= 1'b1;
            end
        join
        src.write_byte(b[2]);
        repeat (8) @(posedge clk);
        foreach (b[i]) `CHK(got[i], b[i])
        `CHK(done, 1'b1)
        v[0] = ~dout;
        src.send_bits(v, 1);
        `CHK(dout, ~v[0])
        $display("test slave byte done");

        @(posedge clk);
        src.din <= 1'b1;
        restart(`CMP_MODE_MSER, 16, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(cfg_clk_oe, 1'b1)
        cfg_clk_high(n);
        `CHK(n, `CMP_SLOW_HALF + 1)
        wait_flag(1, 4000);
        repeat (4) @(posedge clk);
        // The first word 8'hff carries rate code 4'hf, so a half period of 16 cycles.
        cfg_clk_high(n);
        `CHK(n, 16)
        `CHK(got[0], 8'hff)
        `CHK(got[1], 8'hff)
        `CHK(done, 1'b1)
        $display("test master serial done");

        restart(`CMP_MODE_MBYTE, 8, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(cfg_clk_oe, 1'b1)
        // The device clocks the byte itself, so the source just holds it selected.
        src.data_i <= b[2];
        src.port_dir_n <= 1'b0;
        src.cs_n <= 1'b0;
        wait_flag(1, 400);
        src.cs_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(got[0], b[2])
        $display("test master byte done");

        foreach (modes[k]) begin
            restart(modes[k], 8, 1'b0);
            // A pin edge here would shift the word if pin loading were still live.
            src.send_bits(8'h01, 1);
            v = 8'($random(seed));
            for (int i = 7; i >= 0; i--) begin
                @(posedge clk);
                tap_bit_valid <= 1'b1;
                tap_bit <= v[i];
                @(posedge clk);
                tap_bit_valid <= 1'b0;
                repeat (2) @(posedge clk);
            end
            repeat (4) @(posedge clk);
            `CHK(got[0], v)
            `CHK(cfg_clk_oe, 1'b0)
            `CHK(done, 1'b1)
        end
        $display("test test-port modes done");

        // A restart seen while the enable is low must wait until it returns.
        clk_en <= 1'b0;
        cfg_restart_n <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(done, 1'b1)
        clk_en <= 1'b1;
        repeat (12) @(posedge clk);
        `CHK(done, 1'b0)
        $display("test freeze and restart done");
        final_report();
    end
endmodule // config_mode_port_test
